// File: hdl/ssf_pkg.sv
/*
 * Package of the synchronous serial framing block: frame formats, data-size
 * limits, command/response layout, FIFO depth, divider and link timing.
 * Assumes a host on clk (40 MHz) and a link clock from an external source.
 */
// What this block does
// - Frames carry 4 to 16 data bits as set by the data-size field, in every format.
// - Every frame is shifted out most significant bit first.
// - The serial clock rests low whenever nothing is being transferred, except in SPI format with polarity set, where it rests high.
// - The serial clock toggles only during the command and data bits of a frame.
// - The frame signal marks where each transfer starts, and in SPI and command/response formats also where it ends.
// - A line-driver enable output gates an external transmit line driver.
// - In pulsed-frame format the frame signal is high for one bit period before each frame.
// - In pulsed-frame format data changes on the rising edge and is sampled on the falling.
// - In SPI format the frame signal is active low while the slave is selected.
// - In SPI format polarity and phase settings govern the clock only; frame goes high between frames, also back to back.
// - In command/response format frame is active low, data changes on falling, sampled rising.
// - In command/response format an 8-bit command goes first and input is ignored meanwhile.
package ssf_pkg;

    // ****************************************************************
    // Frame formats and sizes
    // ****************************************************************
    typedef enum logic [1:0] {
        FMT_PULSED  = 2'h0,
        FMT_SPI     = 2'h1,
        FMT_CMDRESP = 2'h2
    } ssf_format_t;

    localparam logic [3:0] DSS_MIN      = 4'h3;  // data size field holds length minus one
    localparam int         WORD_W       = 16;
    localparam int         CMD_BITS     = 8;
    localparam int         FIFO_DEPTH   = 16;
    localparam int         SYNC_STAGES  = 2;

    // ****************************************************************
    // Bit clock timing
    // ****************************************************************
    localparam real        LINK_PERIOD_NS = 80.0;
    // The link clock runs twice the bit rate; each bit takes two link cycles.
    localparam int         HALF_BIT_CYC   = 1;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LEAD  = 3'h1,
        ST_SHIFT = 3'h2,
        ST_TURN  = 3'h3,
        ST_RESP  = 3'h4,
        ST_TAIL  = 3'h5
    } ssf_state_t;

endpackage

// File: hdl/ssf_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/1ps
module ssf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Write side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Read side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] memArr [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = memArr[rdPtr_reg];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWr) begin
            memArr[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doWr && !doRd) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRd && !doWr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// File: hdl/ssf_sync.sv
/*
 * Two-flop synchroniser for a single level.
 * Assumes the input is a level that stays put for several destination cycles.
 */
`timescale 1ns/1ps
module ssf_sync (
    // Destination clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Level in and out
    input  wire logic levelIn,
    output logic      levelOut
);
    logic meta_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 1'b0;
            levelOut <= 1'b0;
        end else begin
            meta_reg <= levelIn;
            levelOut <= meta_reg;
        end
    end
endmodule

// File: hdl/ssf_framer.sv
/*
 * Framing master of the synchronous serial port: bit clock, frame signal,
 * transmit data, line-driver enable, receive capture.
 * Assumes a host on clk that pushes words into a FIFO and takes received
 * words, and a free-running link clock at twice the bit rate.
 */
`timescale 1ns/1ps
module ssf_framer
    import ssf_pkg::*;
(
    // Host clock domain
    input  wire logic         clk,
    input  wire logic         reset,
    // Configuration, stable while a frame runs
    input  wire logic [1:0]   frameFormat,
    input  wire logic [3:0]   dataSize,
    input  wire logic         clock_polarity_sel,
    input  wire logic         clock_phase_sel,
    input  wire logic [7:0]   cmdWord,
    // Transmit words from the host
    input  wire logic         txValid,
    output logic              txReady,
    input  wire logic [15:0]  txData,
    // Received words toward the host
    output logic              rxValid_reg,
    output logic [15:0]       rxData_reg,
    output logic              busy_reg,
    // Link side
    input  wire logic         linkClk,
    output logic              serial_bit_clock,
    output logic              frame_sync,
    output logic              serialOut,
    output logic              line_driver_enable,
    input  wire logic         serialIn
);

    // ****************************************************************
    // Transmit FIFO on the host clock
    // ****************************************************************
    logic        fifoValid;
    logic        fifoReady;
    logic [15:0] fifoData;

    ssf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) txFifo (
        .clk      (clk),
        .reset    (reset),
        .inValid  (txValid),
        .inReady  (txReady),
        .inData   (txData),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoData)
    );

    // ****************************************************************
    // Word handshake into the link domain
    // ****************************************************************
    // A four-phase request/acknowledge carries one word; the holding
    // register stays steady while the request is up, so the link side
    // may read it after synchronising the request.
    logic        req_reg;
    logic [15:0] hold_reg;
    logic [1:0]  fmtHold_reg;
    logic [3:0]  sizeHold_reg;
    logic        ackSync;
    logic        reqSync;
    logic        ack_reg;

    assign fifoReady = !req_reg && !ackSync;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_reg      <= 1'b0;
            hold_reg     <= 16'h0000;
            fmtHold_reg  <= 2'h0;
            sizeHold_reg <= 4'h7;
        end else if (fifoValid && fifoReady) begin
            req_reg      <= 1'b1;
            hold_reg     <= fifoData;
            fmtHold_reg  <= frameFormat;
            sizeHold_reg <= (dataSize < DSS_MIN) ? DSS_MIN : dataSize;
        end else if (ackSync) begin
            req_reg <= 1'b0;
        end
    end

    ssf_sync ackSyncInst (.clk(clk), .reset(reset), .levelIn(ack_reg), .levelOut(ackSync));
    ssf_sync reqSyncInst (.clk(linkClk), .reset(reset), .levelIn(req_reg), .levelOut(reqSync));

    // Polarity and phase are static settings, still passed through two flops.
    logic polSync;
    logic phaSync;
    ssf_sync polSyncInst (.clk(linkClk), .reset(reset), .levelIn(clock_polarity_sel),
                          .levelOut(polSync));
    ssf_sync phaSyncInst (.clk(linkClk), .reset(reset), .levelIn(clock_phase_sel),
                          .levelOut(phaSync));

    // ****************************************************************
    // Link domain frame engine
    // ****************************************************************
    // Each bit spans two link cycles: phase 0 is the first half, phase 1 the
    // second. The bit clock output is high in the first half of each bit for
    // pulsed format, low for command format, and set by polarity/phase for SPI.
    ssf_state_t  state_reg;
    logic        half_reg;
    logic [4:0]  bitCnt_reg;
    logic [15:0] shift_reg;
    logic [15:0] rxShift_reg;
    logic [1:0]  fmt_reg;
    logic [3:0]  size_reg;
    logic [7:0]  cmd_reg;
    logic        rxToggle_reg;
    logic [15:0] rxWord_reg;
    logic        sinA_reg;
    logic        sinB_reg;
    logic        spiPol;
    logic        spiPha;
    logic        active;

    assign spiPol = (fmt_reg == FMT_SPI) && polSync;
    // High where data launches on the leading clock edge of a bit: pulsed
    // format always, SPI with phase set. Command format launches on falling.
    assign spiPha = (fmt_reg == FMT_PULSED) || ((fmt_reg == FMT_SPI) && phaSync);
    assign active = (state_reg == ST_SHIFT) || (state_reg == ST_RESP);

    // Serial input through two flops before any use.
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            sinA_reg <= 1'b0;
            sinB_reg <= 1'b0;
        end else begin
            sinA_reg <= serialIn;
            sinB_reg <= sinA_reg;
        end
    end

    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            state_reg    <= ST_IDLE;
            half_reg     <= 1'b0;
            bitCnt_reg   <= 5'h00;
            shift_reg    <= 16'h0000;
            rxShift_reg  <= 16'h0000;
            fmt_reg      <= 2'h0;
            size_reg     <= 4'h7;
            cmd_reg      <= 8'h00;
            ack_reg      <= 1'b0;
            rxToggle_reg <= 1'b0;
            rxWord_reg   <= 16'h0000;
        end else begin
            half_reg <= !half_reg;
            if (!reqSync) begin
                ack_reg <= 1'b0;
            end
            unique case (state_reg)
                ST_IDLE: begin
                    half_reg <= 1'b0;
                    if (reqSync && !ack_reg) begin
                        ack_reg   <= 1'b1;
                        fmt_reg   <= fmtHold_reg;
                        size_reg  <= sizeHold_reg;
                        shift_reg <= hold_reg << (5'd15 - {1'b0, sizeHold_reg});
                        cmd_reg   <= cmdWord;
                        state_reg <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    // One full bit period of frame lead-in before the data.
                    if (half_reg) begin
                        bitCnt_reg <= (fmt_reg == FMT_CMDRESP) ? 5'(CMD_BITS - 1)
                                                                : {1'b0, size_reg};
                        state_reg  <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (half_reg) begin
                        if (fmt_reg == FMT_CMDRESP) begin
                            cmd_reg <= {cmd_reg[6:0], 1'b0};
                        end else begin
                            shift_reg   <= {shift_reg[14:0], 1'b0};
                            rxShift_reg <= {rxShift_reg[14:0], sinB_reg};
                        end
                        if (bitCnt_reg == 5'h00) begin
                            state_reg <= (fmt_reg == FMT_CMDRESP) ? ST_TURN : ST_TAIL;
                        end else begin
                            bitCnt_reg <= bitCnt_reg - 5'h01;
                        end
                    end
                end
                ST_TURN: begin
                    // Idle bit while the slave decodes the command.
                    if (half_reg) begin
                        bitCnt_reg <= {1'b0, size_reg};
                        state_reg  <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (half_reg) begin
                        rxShift_reg <= {rxShift_reg[14:0], sinB_reg};
                        if (bitCnt_reg == 5'h00) begin
                            state_reg <= ST_TAIL;
                        end else begin
                            bitCnt_reg <= bitCnt_reg - 5'h01;
                        end
                    end
                end
                ST_TAIL: begin
                    // The input lags two link cycles behind the pin, so each
                    // capture holds the previous bit; the last bit is picked up
                    // here and the stale first capture falls off the top.
                    if (half_reg) begin
                        rxWord_reg   <= {rxShift_reg[14:0], sinB_reg}
                                        & ~(16'hFFFE << size_reg);
                        rxToggle_reg <= !rxToggle_reg;
                        state_reg    <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Link outputs, all registered
    // ****************************************************************
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            serial_bit_clock   <= 1'b0;
            frame_sync         <= 1'b0;
            serialOut          <= 1'b0;
            line_driver_enable <= 1'b0;
        end else begin
            // Clock moves only inside command and data bits; otherwise it rests at idle.
            if (active) begin
                serial_bit_clock <= spiPol ^ (spiPha ? !half_reg : half_reg);
            end else begin
                serial_bit_clock <= spiPol;
            end
            unique case (fmt_reg)
                FMT_PULSED:
                    frame_sync <= (state_reg == ST_LEAD);
                FMT_SPI:
                    frame_sync <= (state_reg == ST_IDLE);
                default:
                    frame_sync <= (state_reg == ST_IDLE);
            endcase
            // Data launched at the start of each bit; the slave samples mid-bit.
            if (state_reg == ST_SHIFT) begin
                serialOut <= (fmt_reg == FMT_CMDRESP) ? cmd_reg[7] : shift_reg[15];
            end else begin
                serialOut <= 1'b0;
            end
            // Driver enabled only while this end owns the data line.
            line_driver_enable <= (state_reg == ST_LEAD) || (state_reg == ST_SHIFT);
        end
    end
    // The frame output brackets the whole transfer in SPI and command formats; pulsed format gets a one-bit lead pulse.

    // ****************************************************************
    // Received word back to the host domain
    // ****************************************************************
    logic rxTogSync;
    logic rxTogSeen_reg;
    ssf_sync rxSyncInst (.clk(clk), .reset(reset), .levelIn(rxToggle_reg), .levelOut(rxTogSync));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxTogSeen_reg <= 1'b0;
            rxValid_reg   <= 1'b0;
            rxData_reg    <= 16'h0000;
        end else begin
            rxTogSeen_reg <= rxTogSync;
            rxValid_reg   <= (rxTogSync != rxTogSeen_reg);
            if (rxTogSync != rxTogSeen_reg) begin
                rxData_reg <= rxWord_reg;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= fifoValid || req_reg;
        end
    end
endmodule

// File: test/ssf_framer_monitor.sv
/*
 * Link-side checker of the serial framing master.
 * Assumes it is bound to ssf_framer and that settings change only between frames.
 */
`timescale 1ns/1ps
module ssf_framer_monitor
    import ssf_pkg::*;
(
    // Clock and reset
    input wire logic       linkClk,
    input wire logic       reset,
    // Settings
    input wire logic [1:0] frameFormat,
    input wire logic       clock_polarity_sel,
    input wire logic       clock_phase_sel,
    // Link pins
    input wire logic       serial_bit_clock,
    input wire logic       frame_sync,
    input wire logic       serialOut
);
    default clocking cb @(posedge linkClk); endclocking
    default disable iff (reset);

    property p_idle_low;
        frameFormat == FMT_CMDRESP && frame_sync |-> !serial_bit_clock;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle clock high");
    // A polarity change moves the idle level; it needs a few cycles to cross over.
    property p_spi_quiet;
        frameFormat == FMT_SPI && $changed(serial_bit_clock)
            && clock_polarity_sel == $past(clock_polarity_sel, 5) |-> !frame_sync;
    endproperty
    a_spi_quiet: assert property (p_spi_quiet) else $error("clock outside frame");
    property p_pulse_one;
        frameFormat == FMT_PULSED && $rose(frame_sync) |=> frame_sync ##1 !frame_sync;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("frame pulse width");
    property p_pulsed_edge;
        frameFormat == FMT_PULSED && $fell(serial_bit_clock) |-> $stable(serialOut);
    endproperty
    a_pulsed_edge: assert property (p_pulsed_edge) else $error("data moved on fall");
    property p_cmd_edge;
        frameFormat == FMT_CMDRESP && !frame_sync && $rose(serial_bit_clock) |-> $stable(serialOut);
    endproperty
    a_cmd_edge: assert property (p_cmd_edge) else $error("data moved on rise");
    property p_spi_edge;
        frameFormat == FMT_SPI && !frame_sync && $changed(serial_bit_clock)
            && ((serial_bit_clock != clock_polarity_sel) != clock_phase_sel) |-> $stable(serialOut);
    endproperty
    a_spi_edge: assert property (p_spi_edge) else $error("data moved on sample");
    property p_spi_len;
        frameFormat == FMT_SPI && $fell(frame_sync) |-> ##[8:40] $rose(frame_sync);
    endproperty
    a_spi_len: assert property (p_spi_len) else $error("select length");
    property p_cmd_len;
        frameFormat == FMT_CMDRESP && $fell(frame_sync) |-> ##[26:60] $rose(frame_sync);
    endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("cmd frame length");
endmodule

// File: test/ssf_slave_model.sv
/*
 * Behavioural serial slave: records what it hears and replies with respWord.
 * Assumes the bench mirrors the framer settings onto its inputs.
 */
`timescale 1ns/1ps
module ssf_slave_model
    import ssf_pkg::*;
(
    // Settings
    input wire logic [1:0]  frameFormat,
    input wire logic [3:0]  dataSize,
    input wire logic        clock_polarity_sel,
    input wire logic        clock_phase_sel,
    input wire logic [15:0] respWord,
    // Link pins
    input wire logic        serial_bit_clock,
    input wire logic        frame_sync,
    input wire logic        serialOut,
    output logic            serialIn,
    // Heard bits
    output logic [31:0]     gotBits,
    output logic [7:0]      gotCmd
);
    int          nSample = 0;
    int          nFall = 0;
    logic [15:0] shiftReg = 16'h0000;
    logic        sampleOnRise;

    initial serialIn = 1'b0;
    initial gotBits = 32'h0;
    initial gotCmd = 8'h00;

    // A released line shows the inverse of its last level, never a stale bit.
    always @(frame_sync) begin
        if (frameFormat != FMT_PULSED || frame_sync) begin
            nSample = 0;
            nFall = 0;
            shiftReg = 16'(respWord << (4'hF - dataSize));
            serialIn = (frameFormat == FMT_SPI && !frame_sync) || frameFormat == FMT_PULSED
                ? shiftReg[15] : ~serialIn;
        end
    end

    always @(serial_bit_clock) begin
        sampleOnRise = frameFormat == FMT_CMDRESP
            || (frameFormat == FMT_SPI && clock_polarity_sel == clock_phase_sel);
        if (frameFormat == FMT_PULSED || !frame_sync) begin
            if (serial_bit_clock == sampleOnRise) begin
                gotBits = {gotBits[30:0], serialOut};
                if (nSample < CMD_BITS)
                    gotCmd = {gotCmd[6:0], serialOut};
                nSample++;
            end else if (frameFormat == FMT_CMDRESP) begin
                nFall++;
                // The reply's first bit launches on the last command fall and
                // stands through the idle bit.
                if (nFall >= CMD_BITS) begin
                    serialIn = shiftReg[15];
                    shiftReg = shiftReg << 1;
                end
            end else if (nSample > 0) begin
                shiftReg = shiftReg << 1;
                serialIn = shiftReg[15];
            end
        end
    end
endmodule

// File: test/ssf_framer_tb.sv
/*
 * Self-checking bench of the serial framing master with a slave model.
 * Assumes the monitor and slave model files are compiled before this one.
 */
`timescale 1ns/1ps
module ssf_framer_tb
    import ssf_pkg::*;
    ;
    typedef struct packed {
        logic [1:0]  fmt;
        logic        pol;
        logic        pha;
        logic [3:0]  size;
        logic [15:0] tx;
        logic [15:0] resp;
    } ssf_row_t;
    ssf_row_t    rows [9];
    logic        clk = 1'b0;
    logic        linkClk = 1'b0;
    logic        reset = 1'b1;
    logic [1:0]  frameFormat = 2'h0;
    logic [3:0]  dataSize = 4'h3;
    logic        clock_polarity_sel = 1'b0;
    logic        clock_phase_sel = 1'b0;
    logic [7:0]  cmdWord = 8'h00;
    logic        txValid = 1'b0;
    logic [15:0] txData = 16'h0000;
    logic [15:0] respWord = 16'h0000;
    logic        txReady, rxValid_reg, busy_reg, serial_bit_clock, frame_sync;
    logic        serialOut, line_driver_enable, serialIn, seenEn;
    logic [15:0] rxData_reg, mask;
    logic [31:0] gotBits;
    logic [7:0]  gotCmd;
    int          n_mismatch = 0, comparisons = 0, cycles = 0, nRx = 0, nAcc = 0;

    ssf_framer dut_u (.clk, .reset, .frameFormat, .dataSize, .clock_polarity_sel,
        .clock_phase_sel, .cmdWord, .txValid, .txReady, .txData, .rxValid_reg, .rxData_reg,
        .busy_reg, .linkClk, .serial_bit_clock, .frame_sync, .serialOut, .line_driver_enable,
        .serialIn);
    ssf_slave_model model_u (.frameFormat, .dataSize, .clock_polarity_sel, .clock_phase_sel,
        .respWord, .serial_bit_clock, .frame_sync, .serialOut, .serialIn, .gotBits, .gotCmd);

    always #12.5 clk = ~clk;
    // Offset so the two clocks never share an edge.
    initial begin
        #3.3;
        forever #40 linkClk = ~linkClk;
    end

    always @(posedge clk) begin
        cycles++;
        if (rxValid_reg === 1'b1)
            nRx++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    always @(posedge linkClk) if (line_driver_enable === 1'b1) seenEn <= 1'b1;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic pushWord(input logic [15:0] w);
        txData = w;
        txValid = 1'b1;
        while (txReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        txValid = 1'b0;
    endtask

    task automatic waitRx();
        for (int k = 0; k < 4000 && rxValid_reg !== 1'b1; k++) @(negedge clk);
        repeat (4) @(negedge clk);
    endtask

    initial begin
        rows = '{'{FMT_PULSED, 1'b0, 1'b0, 4'h3, 16'h000A, 16'h0000},
                 '{FMT_PULSED, 1'b0, 1'b0, 4'hF, 16'hC35A, 16'h0000},
                 '{FMT_SPI, 1'b0, 1'b1, 4'h7, 16'h00B4, 16'h0000},
                 '{FMT_SPI, 1'b1, 1'b1, 4'hB, 16'h0A5C, 16'h0000},
                 '{FMT_SPI, 1'b1, 1'b0, 4'hF, 16'h8001, 16'h7FFE},
                 '{FMT_SPI, 1'b0, 1'b0, 4'h3, 16'h0009, 16'h0006},
                 '{FMT_CMDRESP, 1'b0, 1'b0, 4'h3, 16'h00A7, 16'h000B},
                 '{FMT_CMDRESP, 1'b0, 1'b0, 4'hF, 16'h005C, 16'hBEEF},
                 '{FMT_CMDRESP, 1'b0, 1'b0, 4'h8, 16'h00E1, 16'h01A5}};
        seenEn = 1'b0;
        repeat (5) @(negedge clk);
        check(16'({txReady, serial_bit_clock, frame_sync, line_driver_enable, busy_reg}),
              16'h0010);
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        foreach (rows[i]) begin
            frameFormat = rows[i].fmt;
            clock_polarity_sel = rows[i].pol;
            clock_phase_sel = rows[i].pha;
            dataSize = rows[i].size;
            cmdWord = rows[i].tx[7:0];
            respWord = rows[i].resp;
            mask = 16'((32'h1 << ({1'b0, dataSize} + 5'h1)) - 32'h1);
            repeat (20) @(negedge clk);
            seenEn = 1'b0;
            pushWord(rows[i].tx);
            waitRx();
            if (frameFormat == FMT_CMDRESP) begin
                check(16'(gotCmd), 16'(cmdWord));
                check(rxData_reg, respWord & mask);
            end else begin
                check(gotBits[15:0] & mask, rows[i].tx & mask);
                if (frameFormat == FMT_SPI && !clock_phase_sel)
                    check(rxData_reg, respWord & mask);
            end
            check(16'(seenEn), 16'h0001);
        end
        // Fill the buffer until it refuses; the link drains it frame after frame.
        frameFormat = FMT_SPI;
        dataSize = 4'hF;
        nRx = 0;
        txData = 16'hA5C0;
        txValid = 1'b1;
        while (txReady === 1'b1 && nAcc < 40) begin
            @(negedge clk);
            nAcc++;
            txData = 16'hA5C0 + 16'(nAcc);
        end
        txValid = 1'b0;
        check(16'(nAcc >= FIFO_DEPTH), 16'h0001);
        for (int k = 0; k < 8000 && nRx < nAcc; k++) @(negedge clk);
        repeat (4) @(negedge clk);
        check(16'(nRx), 16'(nAcc));
        check(gotBits[15:0], txData - 16'h0001);
        stop_test();
    end
endmodule

bind ssf_framer ssf_framer_monitor mon_u (.linkClk, .reset, .frameFormat, .clock_polarity_sel,
    .clock_phase_sel, .serial_bit_clock, .frame_sync, .serialOut);
